// *** design/clock_route_slice.v ***
`timescale 1ns/1ps
`include "io_clock_regs.vh"

module clock_route_slice #(
  parameter ALLOW_BYPASS = 0
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [`SEL_WIDTH-1:0] select,
  input wire sync_src,
  input wire onboard_src,
  input wire strobe_xp,
  input wire strobe_bypass,
  output reg clk_out,
  output reg clk_oe
);

  reg next_out;
  reg next_oe;

  // ----------------------------------------------------------------------------
  // Select decode
  // ----------------------------------------------------------------------------
  // Every code without a meaning falls to the default branch, and the bypass code
  // on a slot that may not use it keeps the zero defaults, so neither drives a clock.
  always @* begin
    next_out = 1'b0;
    next_oe = 1'b0;
    case (select)
      `CODE_SYNC: begin
        next_out = sync_src;
        next_oe = 1'b1;
      end
      `CODE_ONBOARD: begin
        next_out = onboard_src;
        next_oe = 1'b1;
      end
      `CODE_STROBE_XP: begin
        next_out = strobe_xp;
        next_oe = 1'b1;
      end
      `CODE_STROBE_BYPASS: begin
        if (ALLOW_BYPASS != 0) begin
          next_out = strobe_bypass;
          next_oe = 1'b1;
        end
      end
      default: begin
        next_out = 1'b0;
        next_oe = 1'b0;
      end
    endcase
  end

  // Output stage; both outputs hold their value while the clock enable is low.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_out <= 1'b0;
      clk_oe <= 1'b0;
    end else if (ce) begin
      clk_out <= next_out;
      clk_oe <= next_oe;
    end
  end

endmodule // clock_route_slice

// *** design/io_bank_clock_crosspoint_select.v ***
// Operation
// - The generation, trigger-line and global clocks come only from the crosspoint output chosen for each.
// - The acquisition clock comes from the crosspoint or from the strobe bypass, as its select code says.
// - Only the acquisition select may take the bypass code five; any other select refuses it.
// - Each select is an unsigned 8-bit value written by software and decoded here.
// - Code zero disables the output and leaves it undriven.
// - Code two routes the backplane sync clock, the 10 MHz reference or the star trigger as configured.
// - Code three routes the onboard oscillator clock.
// - Code four routes the strobe through the crosspoint, and several outputs may share it.
// - Code five passes the strobe around the crosspoint with the same delay as the data channels.
// - Only clock-capable channels may carry a regional clock; the strobe reaches the acquisition clock through the bypass.
`timescale 1ns/1ps
`include "io_clock_regs.vh"

module io_bank_clock_crosspoint_select #(
  parameter DATA_WIDTH = `DATA_CHANNELS,
  parameter [`DATA_CHANNELS-1:0] CLOCK_CAPABLE = `CLOCK_CAPABLE_MASK
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire ref10_in,
  input wire star_trig_in,
  input wire onboard_osc_in,
  input wire strobe_in,
  input wire [DATA_WIDTH-1:0] data_in,
  output wire gen_clk_out,
  output wire gen_clk_oe,
  output wire trig_clk_out,
  output wire trig_clk_oe,
  output wire acq_clk_out,
  output wire acq_clk_oe,
  output wire global_clk_out,
  output wire global_clk_oe,
  output reg [DATA_WIDTH-1:0] data_sync,
  output reg regional_clk,
  output reg regional_clk_valid
);

  localparam RAW_WIDTH = DATA_WIDTH + `SRC_FIXED;

  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  // All outside signals share one bus so that every bit sees the same three
  // stages; this is what keeps the bypass strobe aligned with the data.
  wire [RAW_WIDTH-1:0] raw_in;
  reg [RAW_WIDTH-1:0] sync_a;
  reg [RAW_WIDTH-1:0] sync_b;
  reg [RAW_WIDTH-1:0] sync_c;
  reg [RAW_WIDTH-1:0] filtered;

  assign raw_in = {data_in, strobe_in, onboard_osc_in, star_trig_in, ref10_in};

  genvar gi;
  generate
    for (gi = 0; gi < RAW_WIDTH; gi = gi + 1) begin : g_sync
      // A new level is taken only once the second and third stages agree.
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
          filtered[gi] <= 1'b0;
        end else if (ce) begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
          if (sync_b[gi] == sync_c[gi]) begin
            filtered[gi] <= sync_c[gi];
          end
        end
      end
    end
  endgenerate

  wire ref10_f;
  wire star_f;
  wire osc_f;
  wire strobe_f;
  wire [DATA_WIDTH-1:0] data_f;

  // Named taps of the filtered bus; the order follows the packing of raw_in,
  // so a change there must be mirrored in the source positions.
  assign ref10_f = filtered[`SRC_REF10];
  assign star_f = filtered[`SRC_STAR];
  assign osc_f = filtered[`SRC_OSC];
  assign strobe_f = filtered[`SRC_STROBE];
  assign data_f = filtered[RAW_WIDTH-1:`SRC_FIXED];

  // ----------------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------------
  reg [`SEL_WIDTH-1:0] sel_gen;
  reg [`SEL_WIDTH-1:0] sel_trig;
  reg [`SEL_WIDTH-1:0] sel_acq;
  reg [`SEL_WIDTH-1:0] sel_global;
  reg sync_use_star;
  reg [3:0] region_channel;
  reg region_enable;
  reg bypass_refused;
  reg region_refused;

  wire wr_gen;
  wire wr_trig;
  wire wr_acq;
  wire wr_global;
  wire wr_config;
  wire wr_status;
  wire [`SEL_WIDTH-1:0] wsel;
  wire wsel_is_bypass;
  wire [3:0] wregion;
  wire wregion_ok;

  assign wr_gen = wr && (addr == `ADDR_GEN_SELECT);
  assign wr_trig = wr && (addr == `ADDR_TRIGGER_SELECT);
  assign wr_acq = wr && (addr == `ADDR_ACQ_SELECT);
  assign wr_global = wr && (addr == `ADDR_GLOBAL_SELECT);
  assign wr_config = wr && (addr == `ADDR_CONFIG);
  assign wr_status = wr && (addr == `ADDR_STATUS);

  // Only the low byte of a select write is meaningful; upper bits are dropped.
  assign wsel = wdata[`SEL_WIDTH-1:0];
  assign wsel_is_bypass = (wsel == `CODE_STROBE_BYPASS);
  assign wregion = wdata[`CFG_REGION_MSB:`CFG_REGION_LSB];
  assign wregion_ok = CLOCK_CAPABLE[wregion];

  // Select writes. A bypass code aimed at a non-acquisition slot is refused and
  // the old select is kept, so a bad write never disturbs a running clock.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_gen <= `SELECT_RESET;
      sel_trig <= `SELECT_RESET;
      sel_acq <= `SELECT_RESET;
      sel_global <= `SELECT_RESET;
    end else if (ce) begin
      if (wr_gen && !wsel_is_bypass) begin
        sel_gen <= wsel;
      end
      if (wr_trig && !wsel_is_bypass) begin
        sel_trig <= wsel;
      end
      if (wr_acq) begin
        sel_acq <= wsel;
      end
      if (wr_global && !wsel_is_bypass) begin
        sel_global <= wsel;
      end
    end
  end

  // Configuration: sync clock choice and regional clock channel. A channel that
  // is not clock-capable is refused and the previous choice stays in force.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_use_star <= 1'b0;
      region_channel <= `CFG_REGION_RESET;
      region_enable <= 1'b0;
    end else if (ce && wr_config) begin
      sync_use_star <= wdata[`CFG_SYNC_STAR_BIT];
      region_enable <= wdata[`CFG_REGION_EN_BIT];
      if (wregion_ok) begin
        region_channel <= wregion;
      end
    end
  end

  // Sticky refusal flags, cleared by writing one. A refusal in the same cycle
  // as the clear wins, so no event is lost. Both cannot coincide from the bus
  // since one strobe carries one address, but the order is kept explicit.
  wire set_bypass_refused;
  wire set_region_refused;

  assign set_bypass_refused = wsel_is_bypass && (wr_gen || wr_trig || wr_global);
  assign set_region_refused = wr_config && !wregion_ok;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bypass_refused <= 1'b0;
      region_refused <= 1'b0;
    end else if (ce) begin
      if (set_bypass_refused) begin
        bypass_refused <= 1'b1;
      end else if (wr_status && wdata[`ST_BYPASS_REFUSED_BIT]) begin
        bypass_refused <= 1'b0;
      end
      if (set_region_refused) begin
        region_refused <= 1'b1;
      end else if (wr_status && wdata[`ST_REGION_REFUSED_BIT]) begin
        region_refused <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Crosspoint sources
  // ----------------------------------------------------------------------------
  // The crosspoint costs one register stage; the bypass skips it, so the bypass
  // strobe reaches its pin with the same latency as the registered data below.
  reg xp_sync;
  reg xp_onboard;
  reg xp_strobe;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xp_sync <= 1'b0;
      xp_onboard <= 1'b0;
      xp_strobe <= 1'b0;
    end else if (ce) begin
      xp_sync <= sync_use_star ? star_f : ref10_f;
      xp_onboard <= osc_f;
      xp_strobe <= strobe_f;
    end
  end

  // Data channels take one stage after filtering, matching the bypass strobe.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_sync <= {DATA_WIDTH{1'b0}};
    end else if (ce) begin
      data_sync <= data_f;
    end
  end

  // ----------------------------------------------------------------------------
  // Output slices
  // ----------------------------------------------------------------------------
  wire [`SEL_WIDTH*`NUM_OUTPUTS-1:0] sel_bus;
  wire [`NUM_OUTPUTS-1:0] slice_out;
  wire [`NUM_OUTPUTS-1:0] slice_oe;

  assign sel_bus = {sel_global, sel_acq, sel_trig, sel_gen};

  generate
    for (gi = 0; gi < `NUM_OUTPUTS; gi = gi + 1) begin : g_slice
      // Each output is fed only by its own select; only the acquisition slot
      // is built with the bypass leg.
      clock_route_slice #(
        .ALLOW_BYPASS((gi == `OUT_ACQ) ? 1 : 0)
      ) u_slice (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .select(sel_bus[gi*`SEL_WIDTH +: `SEL_WIDTH]),
        .sync_src(xp_sync),
        .onboard_src(xp_onboard),
        .strobe_xp(xp_strobe),
        .strobe_bypass(strobe_f),
        .clk_out(slice_out[gi]),
        .clk_oe(slice_oe[gi])
      );
    end
  endgenerate

  assign gen_clk_out = slice_out[`OUT_GEN];
  assign gen_clk_oe = slice_oe[`OUT_GEN];
  assign trig_clk_out = slice_out[`OUT_TRIG];
  assign trig_clk_oe = slice_oe[`OUT_TRIG];
  assign acq_clk_out = slice_out[`OUT_ACQ];
  assign acq_clk_oe = slice_oe[`OUT_ACQ];
  assign global_clk_out = slice_out[`OUT_GLOBAL];
  assign global_clk_oe = slice_oe[`OUT_GLOBAL];

  // ----------------------------------------------------------------------------
  // Conflict watch
  // ----------------------------------------------------------------------------
  // The hardware still routes a shared strobe when software breaks the bypass
  // restriction; it only reports the conflict, because refusing would hide it.
  wire conflict;

  assign conflict = (sel_acq == `CODE_STROBE_BYPASS) &&
                    ((sel_gen == `CODE_STROBE_XP) || (sel_trig == `CODE_STROBE_XP) ||
                     (sel_global == `CODE_STROBE_XP));

  // ----------------------------------------------------------------------------
  // Regional clock
  // ----------------------------------------------------------------------------
  // Writes never store a channel that is not clock-capable, but reset loads channel 0,
  // so the mask is checked here too; the strobe is carried by the bypass leg and needs no entry here.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regional_clk <= 1'b0;
      regional_clk_valid <= 1'b0;
    end else if (ce) begin
      regional_clk_valid <= region_enable && CLOCK_CAPABLE[region_channel];
      if (region_enable && CLOCK_CAPABLE[region_channel]) begin
        regional_clk <= data_f[region_channel];
      end else begin
        regional_clk <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------------
  reg [31:0] next_rdata;

  // Read data stands for exactly the cycle after the strobe; unmapped reads
  // return zero, and bits above each field read as zero.
  always @* begin
    next_rdata = 32'h0000_0000;
    case (addr)
      `ADDR_GEN_SELECT: next_rdata[`SEL_WIDTH-1:0] = sel_gen;
      `ADDR_TRIGGER_SELECT: next_rdata[`SEL_WIDTH-1:0] = sel_trig;
      `ADDR_ACQ_SELECT: next_rdata[`SEL_WIDTH-1:0] = sel_acq;
      `ADDR_GLOBAL_SELECT: next_rdata[`SEL_WIDTH-1:0] = sel_global;
      `ADDR_CONFIG: begin
        next_rdata[`CFG_SYNC_STAR_BIT] = sync_use_star;
        next_rdata[`CFG_REGION_MSB:`CFG_REGION_LSB] = region_channel;
        next_rdata[`CFG_REGION_EN_BIT] = region_enable;
      end
      `ADDR_STATUS: begin
        next_rdata[`ST_BYPASS_REFUSED_BIT] = bypass_refused;
        next_rdata[`ST_REGION_REFUSED_BIT] = region_refused;
        next_rdata[`ST_CONFLICT_BIT] = conflict;
        next_rdata[`ST_REGION_ACTIVE_BIT] = regional_clk_valid;
        next_rdata[`ST_OE_MSB:`ST_OE_LSB] = slice_oe;
      end
      `ADDR_DATA: next_rdata[DATA_WIDTH-1:0] = data_sync;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // The read flop clears whenever no read is under way and the clock enable is high, so a stale word can
  // never be mistaken for the answer to a later access.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= rd ? next_rdata : 32'h0000_0000;
    end
  end

endmodule // io_bank_clock_crosspoint_select

// *** design/io_clock_regs.vh ***
`ifndef IO_CLOCK_REGS_VH
`define IO_CLOCK_REGS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_GEN_SELECT 8'h00
`define ADDR_TRIGGER_SELECT 8'h04
`define ADDR_ACQ_SELECT 8'h08
`define ADDR_GLOBAL_SELECT 8'h0c
`define ADDR_CONFIG 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_DATA 8'h18

// ----------------------------------------------------------------------------
// Select codes
// ----------------------------------------------------------------------------
`define SEL_WIDTH 8
`define CODE_TRISTATE 8'h00
`define CODE_SYNC 8'h02
`define CODE_ONBOARD 8'h03
`define CODE_STROBE_XP 8'h04
`define CODE_STROBE_BYPASS 8'h05
`define SELECT_RESET 8'h00

// ----------------------------------------------------------------------------
// Output slots of the crosspoint
// ----------------------------------------------------------------------------
`define NUM_OUTPUTS 4
`define OUT_GEN 0
`define OUT_TRIG 1
`define OUT_ACQ 2
`define OUT_GLOBAL 3

// ----------------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------------
`define CFG_SYNC_STAR_BIT 0
`define CFG_REGION_LSB 4
`define CFG_REGION_MSB 7
`define CFG_REGION_EN_BIT 8
`define CFG_REGION_RESET 4'h0

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define ST_BYPASS_REFUSED_BIT 0
`define ST_REGION_REFUSED_BIT 1
`define ST_CONFLICT_BIT 2
`define ST_REGION_ACTIVE_BIT 3
`define ST_OE_LSB 4
`define ST_OE_MSB 7

// ----------------------------------------------------------------------------
// Data channels and clock-capable map
// ----------------------------------------------------------------------------
`define DATA_CHANNELS 16
`define CLOCK_CAPABLE_MASK 16'hf000
`define SRC_FIXED 4
`define SRC_REF10 0
`define SRC_STAR 1
`define SRC_OSC 2
`define SRC_STROBE 3

`endif

// *** testbench/clock_pin_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Far-side clock source: toggles only while a frame runs
// ----------------------------------------------------------------------------
module clock_pin_model #(
  parameter real HALF = 24.0,
  parameter real PHASE = 1.3
) (
  input wire run,
  output reg pin
);
  // A cycle in flight always completes, so the pin rests low between frames.
  initial begin
    pin = 1'b0;
    #(PHASE);
    forever begin
      wait (run);
      #(HALF) pin = 1'b1;
      #(HALF) pin = 1'b0;
    end
  end
endmodule // clock_pin_model

// *** testbench/crosspoint_checker_asserts.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Port-level checks of the clock crosspoint
// ----------------------------------------------------------------------------
module crosspoint_checker #(
  parameter [15:0] CLOCK_CAPABLE = 16'hf000
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire gen_clk_out,
  input wire gen_clk_oe,
  input wire trig_clk_out,
  input wire trig_clk_oe,
  input wire acq_clk_out,
  input wire acq_clk_oe,
  input wire global_clk_out,
  input wire global_clk_oe,
  input wire regional_clk,
  input wire regional_clk_valid
);
  // Decoded bus events; each counts only while the clock enable lets the flops move.
  wire wr_gen = ce && wr && addr == 8'h00;
  wire wr_trig = ce && wr && addr == 8'h04;
  wire wr_acq = ce && wr && addr == 8'h08;
  wire wr_cfg = ce && wr && addr == 8'h10;
  wire mapped = addr <= 8'h18 && addr[1:0] == 2'b00;
  wire [7:0] code = wdata[7:0];
  wire drive_code = code == 8'h02 || code == 8'h03 || code == 8'h04;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  acq_bypass_on_a: assert property (
    wr_acq && code == 8'h05 ##1 (ce && !wr_acq)[*3] |=> acq_clk_oe) else $error("bypass did not drive acq clock");
  gen_idle_code_a: assert property (
    wr_gen && !drive_code && code != 8'h05 ##1 (ce && !wr_gen)[*3] |=> !gen_clk_oe)
    else $error("idle code still drives gen clock");
  trig_drive_code_a: assert property (
    wr_trig && drive_code ##1 (ce && !wr_trig)[*3] |=> trig_clk_oe) else $error("routed code left trig undriven");
  bypass_never_kept_a: assert property (
    ce && rd && (addr == 8'h00 || addr == 8'h04 || addr == 8'h0c) |=> rdata[7:0] != 8'h05)
    else $error("bypass code held outside acq");
  rdata_quiet_a: assert property (
    ce && !rd |=> rdata == 32'h0) else $error("read data without read");
  unmapped_read_zero_a: assert property (
    ce && rd && !mapped |=> rdata == 32'h0) else $error("unmapped read not zero");
  oe_gates_out_a: assert property (
    !gen_clk_oe && !trig_clk_oe |-> !gen_clk_out && !trig_clk_out) else $error("undriven output toggles");
  acq_glob_gated_a: assert property (
    (!acq_clk_oe |-> !acq_clk_out) and (!global_clk_oe |-> !global_clk_out)) else $error("undriven output high");
  region_enable_a: assert property (
    wr_cfg && wdata[8] && CLOCK_CAPABLE[wdata[7:4]] |-> ##[1:4] regional_clk_valid) else $error("region not valid");
  region_off_a: assert property (
    wr_cfg && !wdata[8] |-> ##[1:4] !regional_clk_valid) else $error("region stays valid");
  regional_gated_a: assert property (
    !regional_clk_valid |-> !regional_clk) else $error("regional clock without valid");

  cover property (wr_acq && code == 8'h05);
  cover property ($rose(regional_clk_valid));
  cover property (ce && rd && addr == 8'h14);
endmodule // crosspoint_checker

bind io_bank_clock_crosspoint_select crosspoint_checker #(.CLOCK_CAPABLE(CLOCK_CAPABLE)) chk (
  .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .gen_clk_out(gen_clk_out), .gen_clk_oe(gen_clk_oe), .trig_clk_out(trig_clk_out), .trig_clk_oe(trig_clk_oe),
  .acq_clk_out(acq_clk_out), .acq_clk_oe(acq_clk_oe), .global_clk_out(global_clk_out),
  .global_clk_oe(global_clk_oe), .regional_clk(regional_clk), .regional_clk_valid(regional_clk_valid));

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`include "io_clock_regs.vh"

module tb_top;
  reg clk, rstn, ce, wr, rd, run;
  reg [7:0] addr;
  reg [31:0] wdata, rv;
  reg [15:0] data_in;
  reg [3:0] outs_q;
  wire [31:0] rdata;
  wire [3:0] outs, oes, srcs;
  wire [15:0] data_sync;
  wire regional_clk, regional_clk_valid;
  integer errors, compares, t, k, e, j;
  integer cnt_o [0:3], cnt_s [0:3], base_o [0:3], base_s [0:3], sel_m [0:3], code_t [0:3];
  integer cfg_m, stat_m, region_m;
  genvar g;

  // ----------------------------------------------------------------------------
  // Design and far-side sources (ref, star, oscillator, strobe)
  // ----------------------------------------------------------------------------
  io_bank_clock_crosspoint_select DUT (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ref10_in(srcs[0]), .star_trig_in(srcs[1]), .onboard_osc_in(srcs[2]),
    .strobe_in(srcs[3]), .data_in(data_in), .gen_clk_out(outs[0]), .gen_clk_oe(oes[0]),
    .trig_clk_out(outs[1]), .trig_clk_oe(oes[1]), .acq_clk_out(outs[2]), .acq_clk_oe(oes[2]),
    .global_clk_out(outs[3]), .global_clk_oe(oes[3]), .data_sync(data_sync), .regional_clk(regional_clk),
    .regional_clk_valid(regional_clk_valid));
  clock_pin_model #(.HALF(50.0), .PHASE(0.7)) ref_src (.run(run), .pin(srcs[0]));
  clock_pin_model #(.HALF(32.0), .PHASE(1.9)) star_src (.run(run), .pin(srcs[1]));
  clock_pin_model #(.HALF(20.0), .PHASE(2.3)) osc_src (.run(run), .pin(srcs[2]));
  clock_pin_model #(.HALF(24.0), .PHASE(1.1)) strobe_src (.run(run), .pin(srcs[3]));

  // Edge counters; comparing counts tolerates the unknown phase of each source.
  generate
    for (g = 0; g < 4; g = g + 1) begin : cnt
      always @(posedge srcs[g]) cnt_s[g] = cnt_s[g] + 1;
    end
  endgenerate
  always @(posedge clk) begin
    for (j = 0; j < 4; j = j + 1) if (outs[j] && !outs_q[j]) cnt_o[j] = cnt_o[j] + 1;
    outs_q <= outs;
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------------------
  // Bus tasks, model and comparison
  // ----------------------------------------------------------------------------
  task check(input string name, input [31:0] seen, input [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task write_reg(input [7:0] a, input [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task read_reg(input [7:0] a, output [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // A bypass code on any slot but acq is refused and the old code kept.
  task set_sel(input integer s, input integer c);
    write_reg(s * 4, c);
    if (c == 5 && s != 2) stat_m = stat_m | 1;
    else sel_m[s] = c;
  endtask

  task write_cfg(input [31:0] d);
    write_reg(8'h10, d);
    if (`CLOCK_CAPABLE_MASK >> d[7:4] & 1) region_m = d[7:4];
    else stat_m = stat_m | 2;
    cfg_m = d;
  endtask

  function integer src_of(input integer s, input integer c);
    if (c == 2) src_of = cfg_m & 1;
    else if (c == 3) src_of = 2;
    else if (c == 4 || (c == 5 && s == 2)) src_of = 3;
    else src_of = -1;
  endfunction

  task check_status;
    read_reg(8'h14, rv);
    check("status", rv[3:0], {cfg_m[8] && (`CLOCK_CAPABLE_MASK >> region_m & 1), 1'b0, stat_m[1:0]});
  endtask

  task frame;
    for (k = 0; k < 4; k = k + 1) begin
      base_o[k] = cnt_o[k];
      base_s[k] = cnt_s[k];
    end
    @(posedge clk) run <= 1'b1;
    repeat (500) @(posedge clk);
    run <= 1'b0;
    repeat (40) @(posedge clk);
    for (k = 0; k < 4; k = k + 1) begin
      e = src_of(k, sel_m[k]);
      check("edges", cnt_o[k] - base_o[k], e < 0 ? 0 : cnt_s[e] - base_s[e]);
      check("oe", oes[k], e >= 0);
    end
  endtask

  task end_sim;
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    rstn = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; run = 1'b0; addr = 8'h00; wdata = 32'h0; data_in = 16'h0;
    outs_q = 4'h0; errors = 0; compares = 0; cfg_m = 0; stat_m = 0; region_m = 0;
    for (k = 0; k < 4; k = k + 1) begin
      cnt_o[k] = 0; cnt_s[k] = 0; sel_m[k] = 0;
    end
    rv = $urandom(32'h2636);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (t = 0; t < 4; t = t + 1) begin
      read_reg(t * 4, rv);
      check("sel_reset", rv, 32'h0);
    end
    check("oe_reset", oes, 4'h0);
    // Every code once on all slots, then random ones; acq is parked first and written last.
    for (t = 0; t < 14; t = t + 1) begin
      write_cfg({23'h0, 1'b0, 4'h0, 3'h0, t[0]});
      for (k = 0; k < 4; k = k + 1) code_t[k] = t < 6 ? (t == 4 ? 5 : t == 5 ? 4 : t) : $urandom % 10;
      for (k = 0; k < 4; k = k + 1) if (code_t[k] > 7) code_t[k] = 6 + $urandom % 250;
      for (k = 0; k < 4; k = k + 1)
        if (code_t[2] == 5 && k != 2 && (code_t[k] == 4 || code_t[k] == 5 && sel_m[k] == 4)) code_t[k] = 0;
      set_sel(2, 0);
      set_sel(0, code_t[0]);
      set_sel(1, code_t[1]);
      set_sel(3, code_t[3]);
      set_sel(2, code_t[2]);
      for (k = 0; k < 4; k = k + 1) begin
        read_reg(k * 4, rv);
        check("select", rv, sel_m[k]);
      end
      frame;
    end
    check_status;
    write_reg(8'h14, 32'h3);
    stat_m = 0;
    check_status;
    // Regional clock: random channel indices, refused unless clock capable.
    for (t = 0; t < 10; t = t + 1) begin
      write_cfg({23'h0, 1'b1, 4'($urandom % 16), 4'h0});
      @(posedge clk) data_in <= $urandom;
      repeat (8) @(posedge clk);
      check("region_valid", regional_clk_valid, `CLOCK_CAPABLE_MASK >> region_m & 1);
      check("region_clk", regional_clk, (`CLOCK_CAPABLE_MASK >> region_m & 1) ? data_in[region_m] : 1'b0);
      check("data_sync_pin", data_sync, data_in);
      read_reg(8'h18, rv);
      check("data_sync", rv[15:0], data_in);
      check_status;
    end
    write_cfg(32'h0);
    repeat (6) @(posedge clk);
    check("region_off", regional_clk_valid, 1'b0);
    read_reg(8'h1c, rv);
    check("unmapped", rv, 32'h0);
    read_reg(8'h02, rv);
    check("unaligned", rv, 32'h0);
    // A write made while the clock enable is low must not land.
    @(posedge clk) ce <= 1'b0;
    write_reg(8'h00, sel_m[0] == 3 ? 2 : 3);
    @(posedge clk) ce <= 1'b1;
    read_reg(8'h00, rv);
    check("ce_hold", rv, sel_m[0]);
    end_sim;
  end

  // Cut a hang short well beyond the expected run of about 30 us.
  initial begin
    #200000;
    errors = errors + 1;
    end_sim;
  end
endmodule // tb_top
